// [otpr_map.vh]
// constants for the one-time area read and protect logic
`ifndef OTPR_MAP_VH
`define OTPR_MAP_VH
// opcodes
`define OTPR_CMD_READ 8'h00
`define OTPR_CMD_READ_GO 8'h30
`define OTPR_CMD_COLCHG 8'h05
`define OTPR_CMD_COLCHG_GO 8'hE0
`define OTPR_CMD_STATUS 8'h70
`define OTPR_CMD_PROG 8'h80
`define OTPR_CMD_PROG_GO 8'h10
`define OTPR_CMD_SETFEAT 8'hEF
`define OTPR_CMD_RESET 8'hFF
// feature address and values
`define OTPR_FEAT_OTP 8'h90
`define OTPR_FEAT_ON 8'h01
`define OTPR_FEAT_OFF 8'h00
// status values and bit positions
`define OTPR_STAT_REJECT 8'h60
`define OTPR_STAT_READY 8'hE0
`define OTPR_STAT_RDY_BIT 6
`define OTPR_STAT_ARRAY_READY_BIT_BIT 5
`define OTPR_STAT_BUSY_MASK 8'h60
// one-time range
`define OTPR_PROTECT_PAGE 8'h01
`define OTPR_START_PAGE 8'h02
`define OTPR_PAGE_COUNT 8'h1E
// address cycle count
`define OTPR_ADDR_CYCLES 3'h5
// timing: figures in ns, counts derived at 125 MHz
`define OTPR_CLK_NS 8
`define OTPR_PAGE_LOAD_NS 35000
`define OTPR_REJECT_BUSY_NS 3000
`define OTPR_PROG_NS 350000
// counts at the timer's width, ns figure over the clock period; keep in step by hand
`define OTPR_PAGE_LOAD_CYC 18'h01117
`define OTPR_REJECT_BUSY_CYC 18'h00177
`define OTPR_PROG_CYC 18'h0AAE6
`endif

// [otpr_busy_timer.v]
// down-counter that times one busy period
`include "otpr_map.vh"
module otpr_busy_timer (
   // clock and reset
   input wire clk,
   input wire resetn,
   // start and length
   input wire start,
   input wire [17:0] length,
   // state
   output wire busy,
   output reg done
);
   reg [17:0] count_reg;

   // count down; done pulses in the cycle busy falls
   always @(posedge clk) begin
      if (!resetn) begin
         count_reg <= 18'h00000;
         done <= 1'b0;
      end else if (start) begin
         count_reg <= (length == 18'h00000) ? 18'h00001 : length;
         done <= 1'b0;
      end else if (count_reg != 18'h00000) begin
         count_reg <= count_reg - 18'h00001;
         done <= (count_reg == 18'h00001);
      end else begin
         done <= 1'b0;
      end
   end

   assign busy = (count_reg != 18'h00000);
endmodule // otpr_busy_timer

// [otpr_area_ctrl.v]
// one-time area command decoder: mode, read, protect and reject handling
// Operation
// - protect when already locked: busy for reject time, then status reads 60h
// - area locks only after protect completes and its status is read
// - after 30h, ready and array-ready bits clear for page load time
// - after polling, 00h switches output from status back to page data
// - data output begins at the column given in the address cycles
// - repeated full read sequences read further pages in one-time mode
// - 05h-E0h during output moves output to the new column
// - feature 90h value 01h, others zero, enters one-time mode
// - feature 90h all zero bytes returns to normal operation
// - reset command leaves one-time mode
// - reads beyond the one-time range return no valid data
`include "otpr_map.vh"
module otpr_area_ctrl (
   // clock and reset
   input wire clk,
   input wire resetn,
   // latched bus cycles from the pin front end, one-cycle strobes
   input wire cmdStrobe,
   input wire addrStrobe,
   input wire dataInStrobe,
   input wire dataOutStrobe,
   input wire [7:0] busIn,
   // page array port, one byte per column
   output reg [12:0] arrayColumn,
   output reg [7:0] arrayPage,
   output wire arrayLoad,
   input wire [7:0] arrayByte,
   // pins and state
   output reg [7:0] busOut,
   output wire readyBusyn,
   output reg otpMode,
   output reg otpLocked,
   output reg dataValid
);
   // ************************************
   // state
   // ************************************
   localparam IDLE = 3'h0;
   localparam ADDR = 3'h1;
   localparam FEAT = 3'h2;
   localparam PROGDATA = 3'h3;
   localparam BUSY = 3'h4;

   reg [2:0] state_reg;
   reg [2:0] addrCount_reg;
   reg [7:0] opcode_reg;
   reg [39:0] addr_reg;
   reg [7:0] feat_reg;
   reg [7:0] featP1_reg;
   reg statusOut_reg;
   reg [7:0] status_reg;
   reg protectPending_reg;
   reg protectDone_reg;
   reg busyIsRead_reg;
   reg rejectBusy_reg;
   reg timerStart;
   reg [17:0] timerLength;
   wire timerBusy;
   wire timerDone;

   otpr_busy_timer i_otpr_busy_timer (
      .clk(clk),
      .resetn(resetn),
      .start(timerStart),
      .length(timerLength),
      .busy(timerBusy),
      .done(timerDone)
   );

   // ready/busy and status bits share one source; the registered status bits follow the pin one cycle later
   assign readyBusyn = ~timerBusy;
   assign arrayLoad = timerDone & busyIsRead_reg;

   // ************************************
   // command sequencer
   // ************************************
   // one clocked process keeps all sequencing state in one place
   always @(posedge clk) begin
      if (!resetn) begin
         state_reg <= IDLE;
         addrCount_reg <= 3'h0;
         opcode_reg <= 8'h00;
         addr_reg <= 40'h0000000000;
         feat_reg <= 8'h00;
         featP1_reg <= 8'h00;
         statusOut_reg <= 1'b0;
         status_reg <= `OTPR_STAT_READY;
         protectPending_reg <= 1'b0;
         protectDone_reg <= 1'b0;
         busyIsRead_reg <= 1'b0;
         rejectBusy_reg <= 1'b0;
         otpMode <= 1'b0;
         otpLocked <= 1'b0;
         arrayColumn <= 13'h0000;
         arrayPage <= 8'h00;
         timerStart <= 1'b0;
         timerLength <= 18'h00000;
      end else begin
         timerStart <= 1'b0;
         // status read taken in every state, busy included, so polling works
         if (cmdStrobe && busIn == `OTPR_CMD_STATUS) begin
            statusOut_reg <= 1'b1;
            // status read confirms a finished protect; a set in BUSY below wins
            if (protectDone_reg) begin
               otpLocked <= 1'b1;
               protectDone_reg <= 1'b0;
            end
         end
         // reset opcode: leave one-time mode from any state
         if (cmdStrobe && busIn == `OTPR_CMD_RESET) begin
            otpMode <= 1'b0;
            statusOut_reg <= 1'b0;
            state_reg <= IDLE;
         end else begin
            case (state_reg)
               IDLE: begin
                  if (cmdStrobe) begin
                     if (busIn == `OTPR_CMD_READ) begin
                        statusOut_reg <= 1'b0;
                        opcode_reg <= busIn;
                        addrCount_reg <= 3'h0;
                        state_reg <= ADDR;
                     end else if (busIn == `OTPR_CMD_COLCHG ||
                                  busIn == `OTPR_CMD_PROG) begin
                        opcode_reg <= busIn;
                        addrCount_reg <= 3'h0;
                        state_reg <= ADDR;
                     end else if (busIn == `OTPR_CMD_SETFEAT) begin
                        addrCount_reg <= 3'h0;
                        state_reg <= FEAT;
                     end
                  end
               end
               ADDR: begin
                  if (addrStrobe) begin
                     addr_reg <= {busIn, addr_reg[39:8]};
                     addrCount_reg <= addrCount_reg + 3'h1;
                     if (opcode_reg == `OTPR_CMD_PROG &&
                         addrCount_reg == `OTPR_ADDR_CYCLES - 3'h1)
                        state_reg <= PROGDATA;
                  end else if (cmdStrobe && busIn == `OTPR_CMD_READ_GO &&
                               opcode_reg == `OTPR_CMD_READ && otpMode) begin
                     // column from cycles 1-2, page from cycle 3
                     arrayColumn <= addr_reg[12:0];
                     arrayPage <= addr_reg[23:16];
                     busyIsRead_reg <= 1'b1;
                     timerLength <= `OTPR_PAGE_LOAD_CYC;
                     timerStart <= 1'b1;
                     state_reg <= BUSY;
                  end else if (cmdStrobe && busIn == `OTPR_CMD_COLCHG_GO &&
                               opcode_reg == `OTPR_CMD_COLCHG) begin
                     // two column cycles only, held in the top of the shifter
                     arrayColumn <= addr_reg[36:24];
                     statusOut_reg <= 1'b0;
                     state_reg <= IDLE;
                  end else if (cmdStrobe && (busIn == `OTPR_CMD_READ ||
                               busIn == `OTPR_CMD_COLCHG || busIn == `OTPR_CMD_PROG)) begin
                     // fresh opcode restarts address collection, so 05h after 00h is kept
                     opcode_reg <= busIn;
                     addrCount_reg <= 3'h0;
                     if (busIn == `OTPR_CMD_READ)
                        statusOut_reg <= 1'b0;
                  end else if (cmdStrobe) begin
                     state_reg <= IDLE;
                  end
               end
               FEAT: begin
                  if (addrStrobe) begin
                     feat_reg <= busIn;
                  end else if (dataInStrobe) begin
                     addrCount_reg <= addrCount_reg + 3'h1;
                     if (addrCount_reg == 3'h0)
                        featP1_reg <= busIn;
                     else if (busIn != `OTPR_FEAT_OFF)
                        featP1_reg <= 8'hFF; // nonzero P2-P4 spoils the write
                     if (addrCount_reg == 3'h3) begin
                        if (feat_reg == `OTPR_FEAT_OTP && busIn == `OTPR_FEAT_OFF) begin
                           if (featP1_reg == `OTPR_FEAT_ON)
                              otpMode <= 1'b1;
                           else if (featP1_reg == `OTPR_FEAT_OFF)
                              otpMode <= 1'b0;
                        end
                        state_reg <= IDLE;
                     end
                  end else if (cmdStrobe) begin
                     state_reg <= IDLE;
                  end
               end
               PROGDATA: begin
                  if (cmdStrobe) begin
                     state_reg <= IDLE;
                     if (busIn == `OTPR_CMD_PROG_GO && otpMode &&
                         addr_reg[23:16] == `OTPR_PROTECT_PAGE) begin
                        busyIsRead_reg <= 1'b0;
                        timerStart <= 1'b1;
                        state_reg <= BUSY;
                        if (otpLocked) begin
                           rejectBusy_reg <= 1'b1;
                           timerLength <= `OTPR_REJECT_BUSY_CYC;
                        end else begin
                           protectPending_reg <= 1'b1;
                           timerLength <= `OTPR_PROG_CYC;
                        end
                     end
                  end
               end
               BUSY: begin
                  if (timerDone) begin
                     state_reg <= IDLE;
                     busyIsRead_reg <= 1'b0;
                     if (rejectBusy_reg)
                        status_reg <= `OTPR_STAT_REJECT;
                     else
                        status_reg <= `OTPR_STAT_READY;
                     if (protectPending_reg)
                        protectDone_reg <= 1'b1;
                     rejectBusy_reg <= 1'b0;
                     protectPending_reg <= 1'b0;
                  end
               end
               default: state_reg <= IDLE;
            endcase
         end
         // column advances per byte read while data output is selected and the pin is ready
         if (dataOutStrobe && !statusOut_reg && !timerBusy)
            arrayColumn <= arrayColumn + 13'h0001;
      end
   end

   // ************************************
   // output byte
   // ************************************
   // status bits track the timer, registered, so busy shows one cycle after the pin
   always @(posedge clk) begin
      if (!resetn) begin
         busOut <= 8'h00;
         dataValid <= 1'b0;
      end else if (statusOut_reg) begin
         busOut <= timerBusy ? (status_reg & ~`OTPR_STAT_BUSY_MASK) : status_reg;
         dataValid <= 1'b0;
      end else begin
         busOut <= arrayByte;
         dataValid <= !timerBusy && (arrayPage < `OTPR_START_PAGE + `OTPR_PAGE_COUNT);
      end
   end
endmodule // otpr_area_ctrl

// [otpr_array_model.sv]
// page array stand-in that answers the controller's column and page port
module otpr_array_model (
   // array port
   input wire [12:0] arrayColumn,
   input wire [7:0] arrayPage,
   output wire [7:0] arrayByte
);
   timeunit 1ns;
   timeprecision 1ps;
   // page and low column byte both mixed in, so a wrong page or low column byte shows up
   assign arrayByte = arrayColumn[7:0] ^ arrayPage ^ 8'h5A;
endmodule // otpr_array_model

// [otpr_area_assertions.sv]
// concurrent checks on the one-time area controller ports
// ****************
// checker
// ****************
module otpr_area_chk (
   // clock and reset
   input wire clk,
   input wire resetn,
   // bus cycles
   input wire cmdStrobe,
   input wire addrStrobe,
   input wire [7:0] busIn,
   // outputs
   input wire [12:0] arrayColumn,
   input wire [7:0] busOut,
   input wire readyBusyn,
   input wire otpMode,
   input wire otpLocked,
   input wire arrayLoad
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!resetn);
   reg [15:0] lowCnt_reg;
   reg [2:0] addrCnt_reg;
   reg [7:0] colLo_reg;
   reg [7:0] colHi_reg;
   wire [12:0] colExp = {colHi_reg[4:0], colLo_reg};
   // busy length cleared by the pin itself, so each period is timed alone
   always @(posedge clk) begin
      lowCnt_reg <= (!resetn || readyBusyn) ? 16'h0000 : lowCnt_reg + 16'h0001;
      if (cmdStrobe)
         addrCnt_reg <= 3'h0;
      else if (addrStrobe)
         addrCnt_reg <= addrCnt_reg + 3'h1;
      if (addrStrobe && addrCnt_reg == 3'h0)
         colLo_reg <= busIn;
      if (addrStrobe && addrCnt_reg == 3'h1)
         colHi_reg <= busIn;
   end
   // full read sequence in back-to-back cycles
   sequence s_read;
      cmdStrobe && busIn == 8'h00 ##1 addrStrobe [*5] ##1 cmdStrobe && busIn == 8'h30 && otpMode;
   endsequence
   // status poll while the pin stays ready
   sequence s_poll;
      cmdStrobe && busIn == 8'h70 && readyBusyn ##1 readyBusyn [*2];
   endsequence
   // the timer loads one edge after the confirm is taken, so the pin drops one later
   chk_load_busy: assert property (s_read |=> ##1 !readyBusyn)
      else $error("pin not busy after read confirm");
   chk_busy_length: assert property ($rose(readyBusyn) |->
      lowCnt_reg == 16'h1117 || lowCnt_reg == 16'h0177 || lowCnt_reg == 16'hAAE6)
      else $error("busy period of wrong length");
   chk_reject_busy: assert property (cmdStrobe && busIn == 8'h10 && otpLocked |=>
      ##1 !readyBusyn ##[374:376] $rose(readyBusyn))
      else $error("reject busy time wrong");
   chk_lock_on_poll: assert property ($rose(otpLocked) |->
      $past(cmdStrobe) && $past(busIn) == 8'h70)
      else $error("area locked without status read");
   chk_ready_bits: assert property (s_poll |-> busOut[6:5] == 2'b11)
      else $error("ready bits low while pin ready");
   chk_reset_exit: assert property (cmdStrobe && busIn == 8'hFF |=> !otpMode)
      else $error("mode kept after reset command");
   chk_start_col: assert property ($rose(readyBusyn) && lowCnt_reg == 16'h1117 |->
      arrayColumn == colExp)
      else $error("output column not the given one");
   chk_col_change: assert property (cmdStrobe && busIn == 8'hE0 |=> arrayColumn == colExp)
      else $error("column change not taken");
   chk_load_pulse: assert property ($rose(readyBusyn) && lowCnt_reg == 16'h1117 |-> arrayLoad)
      else $error("no array load at end of page load");
endmodule // otpr_area_chk
bind otpr_area_ctrl otpr_area_chk i_otpr_area_chk (.clk(clk), .resetn(resetn),
   .cmdStrobe(cmdStrobe), .addrStrobe(addrStrobe), .busIn(busIn), .arrayColumn(arrayColumn),
   .busOut(busOut), .readyBusyn(readyBusyn), .otpMode(otpMode), .otpLocked(otpLocked),
   .arrayLoad(arrayLoad));

// [otpr_area_ctrl_tb.sv]
// self-checking bench for the one-time area controller
module otpr_area_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, resetn = 1'b0, cmdStrobe = 1'b0, addrStrobe = 1'b0;
   logic dataInStrobe = 1'b0, dataOutStrobe = 1'b0;
   logic [7:0] busIn = 8'h00, v;
   wire [12:0] arrayColumn;
   wire [7:0] arrayPage, arrayByte, busOut;
   wire arrayLoad, readyBusyn, otpMode, otpLocked, dataValid;
   int err_count = 0, n_checks = 0, c;
   // ****************
   // harness
   // ****************
   always #4 clk = ~clk;
   otpr_area_ctrl i_otpr_area_ctrl (.clk(clk), .resetn(resetn), .cmdStrobe(cmdStrobe),
      .addrStrobe(addrStrobe), .dataInStrobe(dataInStrobe), .dataOutStrobe(dataOutStrobe),
      .busIn(busIn), .arrayColumn(arrayColumn), .arrayPage(arrayPage), .arrayLoad(arrayLoad),
      .arrayByte(arrayByte), .busOut(busOut), .readyBusyn(readyBusyn), .otpMode(otpMode),
      .otpLocked(otpLocked), .dataValid(dataValid));
   otpr_array_model i_otpr_array_model (.arrayColumn(arrayColumn), .arrayPage(arrayPage),
      .arrayByte(arrayByte));
   // items are {kind, byte}, kind 8 cmd, 4 addr, 2 data in, 1 data out; first item leftmost
   task automatic send(input int n, input logic [95:0] kb);
      for (int i = n - 1; i >= 0; i--) begin
         @(negedge clk);
         {cmdStrobe, addrStrobe, dataInStrobe, dataOutStrobe} = kb[i*12+8 +: 4];
         busIn = kb[i*12 +: 8];
      end
      @(negedge clk);
      {cmdStrobe, addrStrobe, dataInStrobe, dataOutStrobe} = 4'h0;
   endtask
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rd(input logic [7:0] col, input logic [7:0] pg);
      send(7, {12'h800, 4'h4, col, 12'h400, 4'h4, pg, 12'h400, 12'h400, 12'h830});
   endtask
   task automatic feat(input logic [7:0] val);
      send(6, {12'h8EF, 12'h490, 4'h2, val, 12'h200, 12'h200, 12'h200});
      repeat (2) @(negedge clk);
   endtask
   // count low samples of the pin until it is high again; a hang is left to the watchdog
   task automatic busy();
      c = 0;
      while (!(c > 0 && readyBusyn === 1'b1)) begin
         @(negedge clk);
         if (readyBusyn === 1'b0) c++;
      end
   endtask
   task automatic op(input logic [7:0] b);
      send(1, {4'h8, b});
      @(negedge clk);
      v = busOut;
   endtask
   task automatic prot();
      send(8, {12'h880, 12'h400, 12'h400, 12'h401, 12'h400, 12'h400, 12'h200, 12'h810});
      busy();
   endtask
   task automatic t_read();
      feat(8'h01);
      chk("otpMode", 16'h0001, 16'(otpMode));
      rd(8'h05, 8'h02);
      busy();
      chk("load cycles", 16'h1117, 16'(c));
      op(8'h70);
      chk("ready status", 16'h00E0, 16'(v));
      op(8'h00);
      chk("first byte", 16'(8'h05 ^ 8'h02 ^ 8'h5A), 16'(v));
      chk("dataValid", 16'h0001, 16'(dataValid));
      send(1, {12'h100});
      @(negedge clk);
      chk("next byte", 16'(8'h06 ^ 8'h02 ^ 8'h5A), 16'(busOut));
      send(4, {12'h805, 12'h420, 12'h400, 12'h8E0});
      @(negedge clk);
      chk("moved column", 16'(8'h20 ^ 8'h02 ^ 8'h5A), 16'(busOut));
      $display("t_read done");
   endtask
   task automatic t_again();
      rd(8'h00, 8'h03);
      op(8'h70);
      chk("busy status", 16'h0000, 16'(v & 8'h60));
      busy();
      op(8'h00);
      chk("second page", 16'(8'h03 ^ 8'h5A), 16'(v));
      rd(8'h00, 8'h40);
      busy();
      op(8'h00);
      chk("range valid", 16'h0000, 16'(dataValid));
      $display("t_again done");
   endtask
   task automatic t_protect();
      prot();
      chk("prog cycles", 16'hAAE6, 16'(c));
      chk("locked early", 16'h0000, 16'(otpLocked));
      op(8'h70);
      chk("locked", 16'h0001, 16'(otpLocked));
      prot();
      chk("reject cycles", 16'h0177, 16'(c));
      op(8'h70);
      chk("reject status", 16'h0060, 16'(v));
      $display("t_protect done");
   endtask
   task automatic t_exit();
      feat(8'h00);
      chk("mode off", 16'h0000, 16'(otpMode));
      feat(8'h01);
      op(8'hFF);
      chk("reset exit", 16'h0000, 16'(otpMode));
      rd(8'h00, 8'h02);
      repeat (4) @(negedge clk);
      chk("ignored read", 16'h0001, 16'(readyBusyn));
      $display("t_exit done");
   endtask
   task print_verdict();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // main sequence after four reset cycles
   initial begin
      repeat (4) @(negedge clk);
      resetn = 1'b1;
      chk("reset ready", 16'h0001, 16'(readyBusyn));
      t_read();
      t_again();
      t_protect();
      t_exit();
      print_verdict();
   end
   // watchdog well past the expected run of some 57400 cycles
   initial begin
      #(8 * 90000);
      err_count++;
      print_verdict();
   end
endmodule // otpr_area_ctrl_tb
